/* File: hw/phc_params.svh */
`ifndef PHC_PARAMS_SVH
`define PHC_PARAMS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define PHC_IDX_W        10
`define PHC_IDX_SEL_LOW  10'h090
`define PHC_IDX_SEL_HIGH 10'h091
`define PHC_IDX_PAGED    10'h092
`define PHC_IDX_IN_DATA  10'h094
`define PHC_IDX_PAGE     10'h09f

// ****************************************
// page numbers
// ****************************************
`define PHC_PG_FLAGS     2'h0
`define PHC_PG_GUARD     2'h1
`define PHC_PG_SEL       2'h2
`define PHC_PG_SLEW      2'h3

// ****************************************
// field layout and reset values
// ****************************************
`define PHC_HC_PINS      4
`define PHC_P1_PINS      6
`define PHC_P2_PINS      8
`define PHC_FLAG_LSB     0
`define PHC_IRQ_EN_LSB   4
`define PHC_RST_SEL      6'h00
`define PHC_RST_HC       4'h0
`define PHC_RST_PAGE     2'h0

`endif

/* File: hw/phc_pkg.sv */
package phc_pkg;

	// pin function, order matches {high, low} select code
	typedef enum logic [1:0] {
		PHC_FUNC_GPIO,
		PHC_FUNC_ALT1,
		PHC_FUNC_ALT2,
		PHC_FUNC_ALT3
	} phc_func_e;

	typedef struct packed {
		logic [5:0] drive;
	} phc_mux_s;

	typedef struct packed {
		logic [7:0] meta;
		logic [7:0] sync;
	} phc_in_s;

	typedef struct packed {
		logic [1:0]  page;
		logic [5:0]  sel_low;
		logic [5:0]  sel_high;
		logic [3:0]  slew;
		logic [3:0]  guard_en;
		logic [3:0]  oc_flag;
		logic [3:0]  oc_irq_en;
		logic [3:0]  oc_meta;
		logic [3:0]  oc_sync;
		logic        irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} phc_core_s;

endpackage

/* File: hw/phc_port_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface phc_port_if;
	logic [5:0] sel_low;
	logic [5:0] sel_high;
	logic [7:0] in_data;

	modport core  (output sel_low, output sel_high, input in_data);
	modport mux   (input sel_low, input sel_high);
	modport inport(output in_data);
endinterface

`default_nettype wire

/* File: hw/phc_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none
`include "phc_params.svh"

module phc_pin_mux
	import phc_pkg::*;
#(
	parameter int PINS = `PHC_P1_PINS
) (
	// clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            ce,
	// selection from the register file
	phc_port_if.mux              sel,
	// output sources
	input  wire logic [PINS-1:0] gpio_out,
	input  wire logic [PINS-1:0] alt1_out,
	input  wire logic [PINS-1:0] alt2_out,
	input  wire logic [PINS-1:0] alt3_out,
	// pad drive
	output logic      [PINS-1:0] pin_drive
);

	phc_mux_s             r;
	phc_mux_s             next_r;
	wire logic [PINS-1:0] pick;

	// ****************************************
	// per-pin function decode
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < PINS; i++) begin : g_pin
			phc_func_e f;
			logic      p;
			assign f = phc_func_e'({sel.sel_high[i], sel.sel_low[i]});
			always_comb begin
				unique case (f)
					PHC_FUNC_GPIO: p = gpio_out[i];
					PHC_FUNC_ALT1: p = alt1_out[i];
					PHC_FUNC_ALT2: p = alt2_out[i];
					PHC_FUNC_ALT3: p = alt3_out[i];
				endcase
			end
			// one driver per bit: each slice feeds its own net bit
			assign pick[i] = p;
		end
	endgenerate

	always_comb begin
		next_r = r;
		next_r.drive = 6'(pick);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign pin_drive = r.drive[PINS-1:0];

endmodule

`default_nettype wire

/* File: hw/phc_in_route.sv */
`timescale 1ns/1ps
`default_nettype none
`include "phc_params.svh"

module phc_in_route
	import phc_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	// input-only pads
	input  wire logic [7:0] in_pin,
	// synchronised data towards register file
	phc_port_if.inport      port,
	// routed copy for peripheral alternate inputs
	output logic      [7:0] periph_in
);

	phc_in_s r;
	phc_in_s next_r;

	// pads are asynchronous: two flops before any use
	always_comb begin
		next_r = r;
		next_r.meta = in_pin;
		next_r.sync = r.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// every pin fans out to data-in and all its alternate users
	assign port.in_data = r.sync;
	assign periph_in    = r.sync;

endmodule

`default_nettype wire

/* File: hw/phc_core.sv */
// Summary of operation
// - select code {high,low}: 00 gpio, 01 alt one, 10 alt two, 11 alt three
// - low and high select bits live in two registers, reset zero
// - one slew bit per high-current pin: 0 fast, 1 slow, reset zero
// - bits 7:4 of slew and guard registers read zero, write zero
// - one overcurrent guard enable per high-current pin, bits 3:0, reset 0
// - overcurrent on pin n sets flag n, which stays after condition ends
// - writing zero clears a flag; reading zero means nothing latched
// - interrupt enable for pin y at bit y+4 of flags register, reset 0
// - slew, guard, flags share one address, pages 3, 1 and 0
// - second port is eight pins, input only, no output path
// - each second-port pin feeds data-in and peripheral/analog inputs
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "phc_params.svh"

module phc_core
	import phc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// first port: output sources
	input  wire logic [5:0]        gpio_out,
	input  wire logic [5:0]        alt1_out,
	input  wire logic [5:0]        alt2_out,
	input  wire logic [5:0]        alt3_out,
	// first port: pad controls
	output logic      [5:0]        pin_drive,
	output logic      [3:0]        edge_rate_select,
	output logic      [3:0]        overcurrent_guard_enable,
	// first port: overcurrent sensors (asynchronous)
	input  wire logic [3:0]        oc_detect,
	// overcurrent interrupt request
	output logic                   oc_irq,
	// second port: input-only pads
	input  wire logic [7:0]        in_pin,
	output logic      [7:0]        general_input_path
);

	phc_core_s r;
	phc_core_s next_r;

	phc_port_if port ();

	// ****************************************
	// submodules
	// ****************************************
	phc_pin_mux #(
		.PINS (`PHC_P1_PINS)
	) phc_pin_mux_inst (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.sel       (port.mux),
		.gpio_out  (gpio_out),
		.alt1_out  (alt1_out),
		.alt2_out  (alt2_out),
		.alt3_out  (alt3_out),
		.pin_drive (pin_drive)
	);

	// input-only: nothing here drives the second port's pads
	phc_in_route phc_in_route_inst (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.in_pin    (in_pin),
		.port      (port.inport),
		.periph_in (general_input_path)
	);

	assign port.sel_low  = r.sel_low;
	assign port.sel_high = r.sel_high;

	// ****************************************
	// address decode
	// ****************************************
	logic [`PHC_IDX_W-1:0] idx;
	logic                  aligned;
	logic                  setup_hit;
	logic                  commit;

	assign idx       = paddr[ADDR_W-1:2];
	assign aligned   = (paddr[1:0] == 2'h0);
	// one wait state: data is fetched in the first access cycle,
	// writes land on the edge where pready is seen high
	assign setup_hit = psel && penable && !r.pready;
	assign commit    = psel && penable && r.pready && pwrite
	                   && pstrb[0] && !r.pslverr;

	logic        map_ok;
	logic [7:0]  rd_byte;
	logic [3:0]  oc_set;

	// ****************************************
	// shared-address readback
	// ****************************************
	logic [7:0] paged_byte;
	logic       paged_ok;

	// page 2 holds nothing at the shared address
	always_comb begin
		paged_ok   = 1'b1;
		paged_byte = 8'h00;
		unique case (r.page)
			`PHC_PG_SLEW: begin
				paged_byte = {4'h0, r.slew};
			end
			`PHC_PG_GUARD: begin
				paged_byte = {4'h0, r.guard_en};
			end
			`PHC_PG_FLAGS: begin
				paged_byte = {r.oc_irq_en, r.oc_flag};
			end
			default: begin
				paged_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		map_ok  = 1'b0;
		rd_byte = 8'h00;
		if (aligned) begin
			unique case (idx)
				`PHC_IDX_PAGE: begin
					map_ok  = 1'b1;
					rd_byte = {6'h00, r.page};
				end
				`PHC_IDX_SEL_LOW: begin
					map_ok  = (r.page == `PHC_PG_SEL);
					rd_byte = {2'h0, r.sel_low};
				end
				`PHC_IDX_SEL_HIGH: begin
					map_ok  = (r.page == `PHC_PG_SEL);
					rd_byte = {2'h0, r.sel_high};
				end
				`PHC_IDX_PAGED: begin
					map_ok  = paged_ok;
					rd_byte = paged_byte;
				end
				`PHC_IDX_IN_DATA: begin
					// read-only, page zero only, unlike the select registers on page two
					map_ok  = (r.page == `PHC_PG_FLAGS);
					rd_byte = port.in_data;
				end
				default: begin
					map_ok = 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// refusal
	// ****************************************
	// the input-data register has no write path
	logic refuse;

	assign refuse = !map_ok
	                || (pwrite && idx == `PHC_IDX_IN_DATA);

	// ****************************************
	// overcurrent detection
	// ****************************************
	// a sensor on a pin whose guard is off cannot latch a flag
	assign oc_set = r.oc_sync & r.guard_en;

	// ****************************************
	// overcurrent flags and enables, per pin
	// ****************************************
	logic            flags_wr;
	wire logic [3:0] flag_next;
	wire logic [3:0] en_next;

	assign flags_wr = commit && (idx == `PHC_IDX_PAGED)
	                  && (r.page == `PHC_PG_FLAGS);

	genvar n;
	generate
		for (n = 0; n < `PHC_HC_PINS; n++) begin : g_flag
			logic clr;
			// only a written zero clears; a one keeps the flag
			assign clr = flags_wr && !pwdata[`PHC_FLAG_LSB + n];
			// set beats a simultaneous clear, so no event is lost
			assign flag_next[n] = oc_set[n]
			                      || (r.oc_flag[n] && !clr);
			// enable of pin n sits four bits above its flag
			assign en_next[n] = flags_wr
			                    ? pwdata[`PHC_IRQ_EN_LSB + n]
			                    : r.oc_irq_en[n];
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_r = r;

		// sensor synchroniser
		next_r.oc_meta = oc_detect;
		next_r.oc_sync = r.oc_meta;

		// apb handshake
		if (setup_hit) begin
			next_r.pready  = 1'b1;
			next_r.pslverr = refuse;
			next_r.prdata  = pwrite ? 32'h0000_0000
			                        : {24'h00_0000, rd_byte};
		end else if (r.pready) begin
			next_r.pready  = 1'b0;
			next_r.pslverr = 1'b0;
			next_r.prdata  = 32'h0000_0000;
		end

		// register writes
		if (commit) begin
			unique case (idx)
				`PHC_IDX_PAGE: begin
					next_r.page = pwdata[1:0];
				end
				`PHC_IDX_SEL_LOW: begin
					next_r.sel_low = pwdata[5:0];
				end
				`PHC_IDX_SEL_HIGH: begin
					next_r.sel_high = pwdata[5:0];
				end
				`PHC_IDX_PAGED: begin
					unique case (r.page)
						`PHC_PG_SLEW: begin
							next_r.slew = pwdata[3:0];
						end
						`PHC_PG_GUARD: begin
							next_r.guard_en = pwdata[3:0];
						end
						`PHC_PG_FLAGS: begin
							// flags and enables: see g_flag
						end
						default: begin
						end
					endcase
				end
				default: begin
				end
			endcase
		end

		next_r.oc_flag   = flag_next;
		next_r.oc_irq_en = en_next;
		next_r.irq       = |(flag_next & en_next);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r           <= '0;
			r.page      <= `PHC_RST_PAGE;
			r.sel_low   <= `PHC_RST_SEL;
			r.sel_high  <= `PHC_RST_SEL;
			r.slew      <= `PHC_RST_HC;
			r.guard_en  <= `PHC_RST_HC;
			r.oc_flag   <= `PHC_RST_HC;
			r.oc_irq_en <= `PHC_RST_HC;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata                   = r.prdata;
	assign pready                   = r.pready;
	assign pslverr                  = r.pslverr;
	assign edge_rate_select         = r.slew;
	assign overcurrent_guard_enable = r.guard_en;
	assign oc_irq                   = r.irq;

endmodule

`default_nettype wire

/* File: verification/phc_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module phc_core_properties (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pads
	input wire logic [3:0]  edge_rate_select,
	input wire logic [3:0]  overcurrent_guard_enable,
	input wire logic [3:0]  oc_detect,
	input wire logic        oc_irq,
	input wire logic [7:0]  in_pin,
	input wire logic [7:0]  general_input_path
);
	// ****
	// checks
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_access: assert property (
		ce && psel && penable && !pready |=> pready)
		else $error("pready missing");
	a_ready_one_pulse: assert property (
		pready |=> !pready)
		else $error("pready too long");
	a_error_with_ready: assert property (
		pslverr |-> pready)
		else $error("pslverr alone");
	a_read_upper_zero: assert property (
		pready && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	// two sync flops; both edges must be out of reset
	a_input_two_flops: assert property (
		$past(presetn, 2) && $past(presetn)
		&& $past(ce, 2) && $past(ce)
		|-> general_input_path == $past(in_pin, 2))
		else $error("input path delay");
	a_irq_has_cause: assert property (
		$rose(oc_irq) |-> $past(pready && pwrite)
		|| $past(|oc_detect, 3))
		else $error("irq without cause");
	a_pad_ctrl_write: assert property (
		$changed({edge_rate_select, overcurrent_guard_enable})
		|-> $past(pready && pwrite))
		else $error("pad control changed");
	a_reset_outputs_low: assert property (
		!$past(presetn) |-> !pready && !oc_irq
		&& edge_rate_select == 4'h0
		&& overcurrent_guard_enable == 4'h0)
		else $error("outputs after reset");
endmodule
bind phc_core phc_core_properties phc_core_properties_inst (
	.pclk, .presetn, .ce, .psel, .penable, .pwrite, .prdata,
	.pready, .pslverr, .edge_rate_select, .overcurrent_guard_enable,
	.oc_detect, .oc_irq, .in_pin, .general_input_path);
`default_nettype wire

/* File: verification/phc_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "phc_params.svh"
module phc_core_bench
	import phc_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  gpio_out = 6'h01;
	logic [5:0]  alt1_out = 6'h02;
	logic [5:0]  alt2_out = 6'h04;
	logic [5:0]  alt3_out = 6'h08;
	logic [5:0]  pin_drive;
	logic [3:0]  edge_rate_select;
	logic [3:0]  overcurrent_guard_enable;
	logic [3:0]  oc_detect = 4'h0;
	logic        oc_irq;
	logic [7:0]  in_pin = 8'h00;
	logic [7:0]  general_input_path;
	logic [31:0] rdat;
	int          err_total = 0;
	int          checks = 0;

	// byte strobe tied: only whole low-byte writes are used
	phc_core phc_core_inst (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb(4'h1), .prdata,
		.pready, .pslverr, .gpio_out, .alt1_out, .alt2_out,
		.alt3_out, .pin_drive, .edge_rate_select,
		.overcurrent_guard_enable, .oc_detect, .oc_irq, .in_pin,
		.general_input_path);

	always #50 pclk = ~pclk;

	// ****
	// helpers
	// ****
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [7:0] d, input logic ee);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		chk("pslverr", 32'(ee), 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 8'h00, 1'b0);
		chk("prdata", e, rdat);
	endtask

	task automatic pg(input logic [1:0] p);
		apb(1'b1, `PHC_IDX_PAGE, {6'h00, p}, 1'b0);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset_values;
		pg(`PHC_PG_SLEW);
		rd(`PHC_IDX_PAGED, 32'h0);
		pg(`PHC_PG_GUARD);
		rd(`PHC_IDX_PAGED, 32'h0);
		pg(`PHC_PG_FLAGS);
		rd(`PHC_IDX_PAGED, 32'h0);
		pg(`PHC_PG_SEL);
		rd(`PHC_IDX_SEL_LOW, 32'h0);
		rd(`PHC_IDX_SEL_HIGH, 32'h0);
	endtask

	// pins 0..3 take codes 00, 01, 10, 11
	task automatic t_func_select;
		chk("pin_drive", 32'h01, 32'(pin_drive));
		apb(1'b1, `PHC_IDX_SEL_LOW, 8'h0a, 1'b0);
		apb(1'b1, `PHC_IDX_SEL_HIGH, 8'h0c, 1'b0);
		rd(`PHC_IDX_SEL_LOW, 32'h0a);
		chk("pin_drive", 32'h0f, 32'(pin_drive));
		alt3_out <= 6'h00;
		repeat (3) @(posedge pclk);
		chk("pin_drive", 32'h07, 32'(pin_drive));
	endtask

	task automatic t_slew_guard;
		pg(`PHC_PG_SLEW);
		apb(1'b1, `PHC_IDX_PAGED, 8'hff, 1'b0);
		rd(`PHC_IDX_PAGED, 32'h0f);
		chk("slew", 32'hf, 32'(edge_rate_select));
		pg(`PHC_PG_GUARD);
		apb(1'b1, `PHC_IDX_PAGED, 8'hfa, 1'b0);
		rd(`PHC_IDX_PAGED, 32'h0a);
		chk("guard", 32'ha, 32'(overcurrent_guard_enable));
		chk("slew", 32'hf, 32'(edge_rate_select));
	endtask

	task automatic t_overcurrent;
		pg(`PHC_PG_FLAGS);
		oc_detect <= 4'hf;
		repeat (6) @(posedge pclk);
		oc_detect <= 4'h0;
		rd(`PHC_IDX_PAGED, 32'h0a);
		chk("oc_irq", 32'h0, 32'(oc_irq));
		apb(1'b1, `PHC_IDX_PAGED, 8'h2a, 1'b0);
		rd(`PHC_IDX_PAGED, 32'h2a);
		chk("oc_irq", 32'h1, 32'(oc_irq));
		apb(1'b1, `PHC_IDX_PAGED, 8'h28, 1'b0);
		rd(`PHC_IDX_PAGED, 32'h28);
		chk("oc_irq", 32'h0, 32'(oc_irq));
		// guarded pin 1 with its enable on raises the request
		oc_detect <= 4'h2;
		repeat (5) @(posedge pclk);
		oc_detect <= 4'h0;
		chk("oc_irq", 32'h1, 32'(oc_irq));
		rd(`PHC_IDX_PAGED, 32'h2a);
	endtask

	task automatic t_errors_and_input;
		apb(1'b1, 10'h093, 8'h00, 1'b1);
		apb(1'b0, `PHC_IDX_SEL_LOW, 8'h00, 1'b1);
		apb(1'b1, `PHC_IDX_IN_DATA, 8'hff, 1'b1);
		in_pin <= 8'ha5;
		repeat (3) @(posedge pclk);
		chk("input", 32'ha5, 32'(general_input_path));
		rd(`PHC_IDX_IN_DATA, 32'ha5);
	endtask

	// ce low freezes the synchroniser with everything else
	task automatic t_freeze;
		ce <= 1'b0;
		in_pin <= 8'h3c;
		repeat (4) @(posedge pclk);
		chk("frozen", 32'ha5, 32'(general_input_path));
		ce <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("input", 32'h3c, 32'(general_input_path));
	endtask

	task automatic tally_and_finish;
		if (err_total == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values;
		t_func_select;
		t_slew_guard;
		t_overcurrent;
		t_errors_and_input;
		t_freeze;
		tally_and_finish;
	end

	// run needs under two hundred cycles
	initial begin
		repeat (5000) @(posedge pclk);
		err_total++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
